// ### hw/cwg_pkg.sv
// Package for the complementary wave generator: register map, fields, resets, types
package cwg_pkg;

  // Register byte offsets
  localparam logic [11:0] CWG_CTRL0_OFS = 12'h000;
  localparam logic [11:0] CWG_INSEL_OFS = 12'h004;
  localparam logic [11:0] CWG_SHDN_OFS = 12'h008;
  localparam logic [11:0] CWG_DBR_OFS = 12'h00C;
  localparam logic [11:0] CWG_DBF_OFS = 12'h010;
  localparam logic [11:0] CWG_STAT_OFS = 12'h014;

  // Control register zero fields
  localparam int CWG_EN_BIT = 7;
  localparam int CWG_OEB_BIT = 6;
  localparam int CWG_OEA_BIT = 5;
  localparam int CWG_POLB_BIT = 4;
  localparam int CWG_POLA_BIT = 3;
  localparam int CWG_CS_BIT = 0;

  // Shutdown control fields
  localparam int CWG_ASE_BIT = 7;
  localparam int CWG_ARSEN_BIT = 6;
  localparam int CWG_LVLB_BIT = 5;
  localparam int CWG_LVLA_BIT = 4;
  localparam int CWG_SRC1_BIT = 1;
  localparam int CWG_SRC0_BIT = 0;

  // Reset values
  localparam logic [7:0] CWG_CTRL0_RST = 8'h00;
  localparam logic [2:0] CWG_INSEL_RST = 3'h0;
  localparam logic [7:0] CWG_SHDN_RST = 8'h00;
  localparam logic [5:0] CWG_DB_RST = 6'h00;

  // Dead-band counter width and oscillator rate
  localparam int CWG_DB_W = 6;
  localparam int CWG_HFOSC_MHZ = 16;

  // Input source encodings
  typedef enum logic [2:0] {
    CWG_IN_CMP1 = 3'h0,
    CWG_IN_CMP2 = 3'h1,
    CWG_IN_PWM_CHANNEL_1 = 3'h2,
    CWG_IN_PWM_CHANNEL_2 = 3'h3,
    CWG_IN_PWM_CHANNEL_3 = 3'h4,
    CWG_IN_PWM_CHANNEL_4 = 3'h5,
    CWG_IN_NCO = 3'h6,
    CWG_IN_LC1 = 3'h7
  } cwg_insel_t;

  // Dead-band phase; Gray along idle -> rising wait -> a on -> falling wait
  typedef enum logic [2:0] {
    CWG_ST_OFF = 3'b000,
    CWG_ST_RWAIT = 3'b001,
    CWG_ST_AON = 3'b011,
    CWG_ST_FWAIT = 3'b010,
    CWG_ST_BON = 3'b110
  } cwg_state_t;

  // Raw signal sources arriving at the block
  typedef struct packed {
    logic comparator1_async_out;
    logic comparator2_async_out;
    logic pwm_channel_1;
    logic pwm_channel_2;
    logic pwm_channel_3;
    logic pwm_channel_4;
    logic nco_output;
    logic logic_cell1_output;
    logic logic_cell2_output;
    logic fault_pin_input;
  } cwg_src_t;

  // Pin drive for both outputs
  typedef struct packed {
    logic output_a;
    logic output_a_oe;
    logic output_b;
    logic output_b_oe;
  } cwg_pins_t;

endpackage : cwg_pkg

// ### hw/cwg_top.sv
// Complementary wave generator with dead band, auto-shutdown and AHB-Lite registers
// Behaviour
// - Clock-select bit picks system clock or 16 MHz internal oscillator for dead band.
// - Two complementary outputs from one input chosen by a three-bit select field.
// - Just after module enable is set both outputs start cleared.
// - Per-output enable; clear leaves pin undriven, set drives override or waveform.
// - While module enable is clear, enables and drive levels have no pin effect.
// - Per-output polarity bit; set is active high, clear is active low.
// - Polarity never alters override levels during shutdown.
// - Two independent 6-bit dead-band registers, for rising and falling edges, sharing one counter.
// - Dead band counts dead-band clock periods from zero up to the register value.
// - Rising edge turns output_b off at once; output_a on after rising count.
// - Falling edge turns output_a off at once; output_b on after falling count.
// - Each dead-band register sets 0 to 63 dead-band clock counts.
// - Dead-band value zero gives no delay; opposite output turns on with the edge.
// - Input returning before count ends keeps the waiting output off for that pulse.
// - Asynchronous input may make dead time vary by one dead-band clock period.
// - Software setting shutdown-active enters shutdown and drives override levels.
// - Without auto-restart, shutdown lasts while the shutdown-active bit stays set.
// - With auto-restart, shutdown-active self-clears; output resumes at next rising edge.
// - Any selected active shutdown input forces override levels at once.
// - Two select bits enable shutdown sources: comparators, logic cell, fault pin.
// - Shutdown inputs are level sensitive; active level holds shutdown.
// - Block runs on while its clock and input run; oscillator request held while enabled, oscillator selected and input high.
// - In shutdown each output equals its override-level bit, uninverted.
// - After shutdown-active clears, overrides stay until first rising input edge.
// - Software clear of shutdown-active takes effect only if selected inputs low.
module cwg_top (
  input wire logic hclk, // System clock, 250 MHz
  input wire logic hresetn, // Asynchronous reset, active low
  input wire logic hsel, // AHB slave select
  input wire logic [31:0] haddr, // AHB address
  input wire logic [1:0] htrans, // AHB transfer type
  input wire logic hwrite, // AHB write
  input wire logic [2:0] hsize, // AHB size
  input wire logic [31:0] hwdata, // AHB write data
  input wire logic hready, // AHB bus ready
  output logic [31:0] hrdata, // AHB read data
  output logic hreadyout, // AHB slave ready
  output logic hresp, // AHB response, always OKAY
  input wire logic hfosc_tick, // Internal oscillator enable pulse, one hclk wide
  input wire cwg_pkg::cwg_src_t src_in, // Raw input and shutdown sources
  output cwg_pkg::cwg_pins_t pins, // Output pin levels and enables
  output logic hfosc_keep_on // Ask the oscillator to stay on in sleep
);

  // Bus address phase capture
  logic wr_pend_q;
  logic [11:0] wr_addr_q;

  // Software-visible control registers
  logic [7:0] ctrl0_q;
  logic [2:0] insel_q;
  logic [7:0] shdn_q;
  logic [5:0] dbr_q;
  logic [5:0] dbf_q;

  // Three-stage synchronisers and the levels they settle on
  logic [2:0] sync1_q;
  logic [2:0] sync2_q;
  logic [2:0] sync3_q;
  logic in_level_q;
  logic fault_q;

  // Dead-band sequencer state
  logic in_prev_q;
  logic [5:0] cnt_q;
  logic armed_q;
  logic en_prev_q;
  cwg_pkg::cwg_state_t st_q;

  // Edge and tick strobes
  logic db_tick;
  logic in_raw;
  logic rise_ev;
  logic fall_ev;

  // Shutdown decode
  logic flt_raw;
  logic sw_ase_wr;
  logic sw_ase_val;
  logic shdn_on;

  // Waveform and pin drive
  logic wave_a;
  logic wave_b;
  logic drv_a;
  logic drv_b;
  logic enable;

  // Input source decode, used for the waveform input
  function automatic logic pick_input(input logic [2:0] sel, input cwg_pkg::cwg_src_t s);
    case (sel)
      cwg_pkg::CWG_IN_CMP1: pick_input = s.comparator1_async_out;
      cwg_pkg::CWG_IN_CMP2: pick_input = s.comparator2_async_out;
      cwg_pkg::CWG_IN_PWM_CHANNEL_1: pick_input = s.pwm_channel_1;
      cwg_pkg::CWG_IN_PWM_CHANNEL_2: pick_input = s.pwm_channel_2;
      cwg_pkg::CWG_IN_PWM_CHANNEL_3: pick_input = s.pwm_channel_3;
      cwg_pkg::CWG_IN_PWM_CHANNEL_4: pick_input = s.pwm_channel_4;
      cwg_pkg::CWG_IN_NCO: pick_input = s.nco_output;
      default: pick_input = s.logic_cell1_output;
    endcase
  endfunction : pick_input

  // AHB-Lite slave: zero wait states, always OKAY
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  // Writes land in the data phase, when hwdata stands
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 12'h000;
    end else if (hready) begin
      wr_pend_q <= hsel && htrans[1] && hwrite;
      wr_addr_q <= haddr[11:0];
    end
  end

  // Read data registered at address phase; unmapped addresses read zero
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (hready && hsel && htrans[1] && !hwrite) begin
      case (haddr[11:0])
        cwg_pkg::CWG_CTRL0_OFS: hrdata <= {24'h000000, ctrl0_q};
        cwg_pkg::CWG_INSEL_OFS: hrdata <= {29'h00000000, insel_q};
        cwg_pkg::CWG_SHDN_OFS: hrdata <= {24'h000000, shdn_q};
        cwg_pkg::CWG_DBR_OFS: hrdata <= {26'h0000000, dbr_q};
        cwg_pkg::CWG_DBF_OFS: hrdata <= {26'h0000000, dbf_q};
        cwg_pkg::CWG_STAT_OFS: hrdata <= {24'h000000, pins, fault_q, in_level_q, st_q == cwg_pkg::CWG_ST_OFF ? 1'b0 : 1'b1, shdn_on};
        default: hrdata <= 32'h0000_0000;
      endcase
    end
  end

  // Plain register writes
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl0_q <= cwg_pkg::CWG_CTRL0_RST;
      insel_q <= cwg_pkg::CWG_INSEL_RST;
      dbr_q <= cwg_pkg::CWG_DB_RST;
      dbf_q <= cwg_pkg::CWG_DB_RST;
    end else if (wr_pend_q) begin
      case (wr_addr_q)
        cwg_pkg::CWG_CTRL0_OFS: ctrl0_q <= {hwdata[7:3], 2'b00, hwdata[0]};
        cwg_pkg::CWG_INSEL_OFS: insel_q <= hwdata[2:0];
        cwg_pkg::CWG_DBR_OFS: dbr_q <= hwdata[5:0];
        cwg_pkg::CWG_DBF_OFS: dbf_q <= hwdata[5:0];
        default: ;
      endcase
    end
  end

  assign enable = ctrl0_q[cwg_pkg::CWG_EN_BIT];
  assign sw_ase_wr = wr_pend_q && (wr_addr_q == cwg_pkg::CWG_SHDN_OFS);
  assign sw_ase_val = hwdata[cwg_pkg::CWG_ASE_BIT];

  // Synchronise waveform input, shutdown sources, in three stages
  assign in_raw = pick_input(insel_q, src_in);
  assign flt_raw = (shdn_q[cwg_pkg::CWG_SRC0_BIT] &&
                    (src_in.comparator1_async_out || src_in.comparator2_async_out))
                || (shdn_q[cwg_pkg::CWG_SRC1_BIT] &&
                    (src_in.logic_cell2_output || src_in.fault_pin_input));

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sync1_q <= 3'h0;
      sync2_q <= 3'h0;
      sync3_q <= 3'h0;
    end else begin
      sync1_q <= {flt_raw, in_raw, 1'b0};
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
    end
  end

  // A change counts once stages two and three agree; the sampling costs at most one tick
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      in_level_q <= 1'b0;
      fault_q <= 1'b0;
    end else begin
      if (sync2_q[1] == sync3_q[1]) in_level_q <= sync3_q[1];
      if (sync2_q[2] == sync3_q[2]) fault_q <= sync3_q[2];
    end
  end

  // Dead-band clock: every hclk or the oscillator tick
  assign db_tick = ctrl0_q[cwg_pkg::CWG_CS_BIT] ? hfosc_tick : 1'b1;
  assign hfosc_keep_on = enable && ctrl0_q[cwg_pkg::CWG_CS_BIT] && in_level_q;

  // Edges of the synchronised input, seen on the dead-band clock
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      in_prev_q <= 1'b0;
      en_prev_q <= 1'b0;
    end else begin
      en_prev_q <= enable;
      if (db_tick) in_prev_q <= in_level_q;
    end
  end
  assign rise_ev = db_tick && in_level_q && !in_prev_q;
  assign fall_ev = db_tick && !in_level_q && in_prev_q;

  // Shutdown-active bit: hardware set wins over any software clear
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      shdn_q <= cwg_pkg::CWG_SHDN_RST;
    end else begin
      if (sw_ase_wr) shdn_q[6:0] <= hwdata[6:0];
      if (fault_q) begin
        shdn_q[cwg_pkg::CWG_ASE_BIT] <= 1'b1;
      end else if (sw_ase_wr && sw_ase_val) begin
        shdn_q[cwg_pkg::CWG_ASE_BIT] <= 1'b1;
      end else if (sw_ase_wr) begin
        shdn_q[cwg_pkg::CWG_ASE_BIT] <= 1'b0;
      end else if (shdn_q[cwg_pkg::CWG_ARSEN_BIT]) begin
        shdn_q[cwg_pkg::CWG_ASE_BIT] <= 1'b0;
      end
    end
  end

  // Overrides persist from shutdown entry until the first rising edge after clear
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      armed_q <= 1'b1;
    end else if (shdn_q[cwg_pkg::CWG_ASE_BIT] || fault_q) begin
      armed_q <= 1'b1;
    end else if (rise_ev) begin
      armed_q <= 1'b0;
    end
  end
  assign shdn_on = shdn_q[cwg_pkg::CWG_ASE_BIT] || fault_q || armed_q;

  // Dead-band sequencer; one counter shared by both edge phases, reset on every edge
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_q <= cwg_pkg::CWG_ST_OFF;
      cnt_q <= 6'h00;
    end else if (!enable || (enable && !en_prev_q)) begin
      st_q <= cwg_pkg::CWG_ST_OFF;
      cnt_q <= 6'h00;
    end else if (rise_ev) begin
      cnt_q <= 6'h00;
      st_q <= (dbr_q == 6'h00) ? cwg_pkg::CWG_ST_AON : cwg_pkg::CWG_ST_RWAIT;
    end else if (fall_ev) begin
      cnt_q <= 6'h00;
      st_q <= (dbf_q == 6'h00) ? cwg_pkg::CWG_ST_BON : cwg_pkg::CWG_ST_FWAIT;
    end else if (db_tick) begin
      case (st_q)
        cwg_pkg::CWG_ST_RWAIT: begin
          cnt_q <= cnt_q + 6'h01;
          if (cnt_q + 6'h01 >= dbr_q) st_q <= cwg_pkg::CWG_ST_AON;
        end
        cwg_pkg::CWG_ST_FWAIT: begin
          cnt_q <= cnt_q + 6'h01;
          if (cnt_q + 6'h01 >= dbf_q) st_q <= cwg_pkg::CWG_ST_BON;
        end
        default: ;
      endcase
    end
  end

  // Active waveform, polarity applied; override bypasses polarity
  assign wave_a = (st_q == cwg_pkg::CWG_ST_AON);
  assign wave_b = (st_q == cwg_pkg::CWG_ST_BON);
  assign drv_a = shdn_on ? shdn_q[cwg_pkg::CWG_LVLA_BIT]
                         : (wave_a ~^ ctrl0_q[cwg_pkg::CWG_POLA_BIT]);
  assign drv_b = shdn_on ? shdn_q[cwg_pkg::CWG_LVLB_BIT]
                         : (wave_b ~^ ctrl0_q[cwg_pkg::CWG_POLB_BIT]);

  // Pin drive registered; nothing reaches the pins without module enable
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pins <= '0;
    end else begin
      pins.output_a <= enable && drv_a;
      pins.output_b <= enable && drv_b;
      pins.output_a_oe <= enable && ctrl0_q[cwg_pkg::CWG_OEA_BIT];
      pins.output_b_oe <= enable && ctrl0_q[cwg_pkg::CWG_OEB_BIT];
    end
  end

  // Never both waveforms on at once
  a_no_overlap: assert property (@(posedge hclk) disable iff (!hresetn)
    !(wave_a && wave_b)) else $error("both waveforms on");

  // Each edge turns the opposite output off on the next clock
  a_rise_b_off: assert property (@(posedge hclk) disable iff (!hresetn)
    (rise_ev && enable && en_prev_q) |=> !wave_b) else $error("b not off on rise");

  a_fall_a_off: assert property (@(posedge hclk) disable iff (!hresetn)
    (fall_ev && enable && en_prev_q) |=> !wave_a) else $error("a not off on fall");

  // A non-zero dead band keeps the waiting output off past the edge
  a_rise_waits: assert property (@(posedge hclk) disable iff (!hresetn)
    (rise_ev && enable && en_prev_q && dbr_q != 6'h00) |=> !wave_a)
    else $error("a on without rising dead band");

  a_fall_waits: assert property (@(posedge hclk) disable iff (!hresetn)
    (fall_ev && enable && en_prev_q && dbf_q != 6'h00) |=> !wave_b)
    else $error("b on without falling dead band");

  // Zero dead band turns the opposite output on with the edge
  a_zero_db: assert property (@(posedge hclk) disable iff (!hresetn)
    (rise_ev && enable && en_prev_q && dbr_q == 6'h00) |=> wave_a)
    else $error("zero dead band delayed");

  a_zero_dbf: assert property (@(posedge hclk) disable iff (!hresetn)
    (fall_ev && enable && en_prev_q && dbf_q == 6'h00) |=> wave_b)
    else $error("zero falling dead band delayed");

  // Between dead-band ticks the sequencer and its counter stand still
  a_tick_hold: assert property (@(posedge hclk) disable iff (!hresetn)
    (enable && en_prev_q && !db_tick) |=> $stable(st_q) && $stable(cnt_q))
    else $error("sequencer moved without a tick");

  // Overrides bypass polarity on both pins
  a_override_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (enable && shdn_on) |=> pins.output_a == $past(shdn_q[cwg_pkg::CWG_LVLA_BIT]))
    else $error("override a wrong");

  a_override_b: assert property (@(posedge hclk) disable iff (!hresetn)
    (enable && shdn_on) |=> pins.output_b == $past(shdn_q[cwg_pkg::CWG_LVLB_BIT]))
    else $error("override b wrong");

  // Polarity set passes the waveform, polarity clear inverts it
  a_pol_high: assert property (@(posedge hclk) disable iff (!hresetn)
    (enable && !shdn_on && ctrl0_q[cwg_pkg::CWG_POLA_BIT])
      |=> pins.output_a == $past(wave_a)) else $error("active-high a wrong");

  a_pol_low: assert property (@(posedge hclk) disable iff (!hresetn)
    (enable && !shdn_on && !ctrl0_q[cwg_pkg::CWG_POLB_BIT])
      |=> pins.output_b != $past(wave_b)) else $error("active-low b wrong");

  // A selected fault sets shutdown-active on the next clock
  a_fault_sets: assert property (@(posedge hclk) disable iff (!hresetn)
    fault_q |=> shdn_q[cwg_pkg::CWG_ASE_BIT]) else $error("fault did not set shutdown");

  // Software set, blocked clear and automatic clear of shutdown-active
  a_sw_sets: assert property (@(posedge hclk) disable iff (!hresetn)
    (sw_ase_wr && sw_ase_val) |=> shdn_q[cwg_pkg::CWG_ASE_BIT])
    else $error("software set of shutdown lost");

  a_clear_blocked: assert property (@(posedge hclk) disable iff (!hresetn)
    (sw_ase_wr && fault_q) |=> shdn_q[cwg_pkg::CWG_ASE_BIT])
    else $error("shutdown cleared under fault");

  a_auto_clears: assert property (@(posedge hclk) disable iff (!hresetn)
    (shdn_q[cwg_pkg::CWG_ARSEN_BIT] && !fault_q && !sw_ase_wr)
      |=> !shdn_q[cwg_pkg::CWG_ASE_BIT]) else $error("auto-restart did not clear");

  // Nothing reaches the pins while the module is off
  a_disabled_quiet: assert property (@(posedge hclk) disable iff (!hresetn)
    !enable |=> !pins.output_a_oe && !pins.output_b_oe && !pins.output_a && !pins.output_b)
    else $error("pins driven while disabled");

  // Enabling starts from both outputs cleared
  a_enable_cleared: assert property (@(posedge hclk) disable iff (!hresetn)
    $rose(enable) |-> st_q == cwg_pkg::CWG_ST_OFF ##1 st_q == cwg_pkg::CWG_ST_OFF)
    else $error("outputs not cleared on enable");

  // Without auto-restart only software ends a shutdown
  a_hold_nors: assert property (@(posedge hclk) disable iff (!hresetn)
    (shdn_q[cwg_pkg::CWG_ASE_BIT] && !shdn_q[cwg_pkg::CWG_ARSEN_BIT] && !sw_ase_wr)
      |=> shdn_q[cwg_pkg::CWG_ASE_BIT]) else $error("shutdown dropped");

  // Overrides outlast shutdown-active until a rising edge, then let go
  a_armed_holds: assert property (@(posedge hclk) disable iff (!hresetn)
    (armed_q && !rise_ev) |=> armed_q) else $error("overrides dropped early");

  a_armed_drops: assert property (@(posedge hclk) disable iff (!hresetn)
    (rise_ev && !shdn_q[cwg_pkg::CWG_ASE_BIT] && !fault_q) |=> !armed_q)
    else $error("overrides kept after rising edge");

endmodule : cwg_top

// ### dv/cwg_switch_model.sv
// Gate-driver model standing on the two switch pins
module cwg_switch_model (
  input wire cwg_pkg::cwg_pins_t pins, // Pin drive from the generator
  output logic pad_a, // Gate level of switch A
  output logic pad_b // Gate level of switch B
);
  timeunit 1ns;
  timeprecision 1ps;
  // Gates carry pull-downs, so a released pin reads off, never a stale level
  assign pad_a = pins.output_a_oe ? pins.output_a : 1'b0;
  assign pad_b = pins.output_b_oe ? pins.output_b : 1'b0;
endmodule : cwg_switch_model

// ### dv/cwg_top_tb.sv
// Self-checking bench for the complementary wave generator
`define CHK(n, e, a) begin checked++; if ((a) !== (e)) begin mismatches++; \
  $display("MISMATCH %s exp %0h got %0h", n, e, a); end end
module cwg_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  // Register offsets and field masks
  localparam logic [11:0] CT0 = cwg_pkg::CWG_CTRL0_OFS, ISL = cwg_pkg::CWG_INSEL_OFS;
  localparam logic [11:0] SHD = cwg_pkg::CWG_SHDN_OFS, DBR = cwg_pkg::CWG_DBR_OFS;
  localparam logic [11:0] DBF = cwg_pkg::CWG_DBF_OFS;
  localparam logic [7:0] EN = 8'h80, OA = 8'h20, CS = 8'h01, RUN = 8'hF8;
  localparam logic [7:0] ASE = 8'h80, ARS = 8'h40, LB = 8'h20, LA = 8'h10;
  localparam logic [7:0] S1 = 8'h02, S0 = 8'h01;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic hfosc_tick = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic hreadyout, hresp, hfosc_keep_on, pad_a, pad_b;
  logic [9:0] sv = 10'h000;
  logic [3:0] tk = 4'h0;
  cwg_pkg::cwg_pins_t pins;
  int mismatches = 0;
  int checked = 0;
  int cyc = 0;

  always #2 hclk = ~hclk;

  cwg_top i_dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .hfosc_tick(hfosc_tick), .src_in(cwg_pkg::cwg_src_t'(sv)), .pins(pins),
    .hfosc_keep_on(hfosc_keep_on)
  );
  cwg_switch_model i_sw (.pins(pins), .pad_a(pad_a), .pad_b(pad_b));

  // Oscillator tick every 16 cycles; a hang limit guards the whole run
  always @(posedge hclk) begin
    tk <= tk + 4'h1;
    hfosc_tick <= (tk == 4'hF);
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      mismatches++;
      stop_test();
    end
  end

  task automatic stop_test();
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : stop_test

  // One single transfer; each phase held until hready is seen high
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {20'h0, a};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask : bus

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    logic [31:0] q;
    bus(1'b1, a, {24'h0, d}, q);
  endtask : wr

  // Move source i and time the gap from one output off to the other on
  task automatic dbchk(input int i, input logic v, input int d, input int tol);
    int n;
    int g;
    n = 0;
    g = 0;
    @(posedge hclk);
    sv[i] <= v;
    while ((v ? pins.output_b : pins.output_a) !== 1'b0 && n < 300) begin
      @(posedge hclk);
      n++;
    end
    while ((v ? pins.output_a : pins.output_b) !== 1'b1 && g < 300) begin
      @(posedge hclk);
      g++;
    end
    `CHK("dead_time", 1'b1, (g >= d - tol && g <= d + tol))
  endtask : dbchk

  // Overrides must outlast a fall; only the next rise brings the waveform
  task automatic resume(input logic [3:0] o, input logic [3:0] e);
    @(posedge hclk);
    sv[7] <= 1'b0;
    repeat (20) @(posedge hclk);
    `CHK("pins", o, pins)
    sv[7] <= 1'b1;
    repeat (20) @(posedge hclk);
    `CHK("pins", e, pins)
  endtask : resume

  task automatic s_reset();
    logic [31:0] q;
    logic [11:0] ofs[4] = '{CT0, SHD, DBR, 12'h018};
    `CHK("pins", 4'h0, pins)
    foreach (ofs[j]) begin
      bus(1'b0, ofs[j], 32'h0, q);
      `CHK("reset_read", 32'h0, q)
    end
  endtask : s_reset

  task automatic s_start();
    wr(DBR, 8'h05);
    wr(DBF, 8'h09);
    wr(SHD, ASE | LB);
    wr(ISL, 8'h02);
    wr(CT0, RUN);
    repeat (4) @(posedge hclk);
    `CHK("pins", 4'h7, pins)
    wr(SHD, LB);
    repeat (10) @(posedge hclk);
    `CHK("pins", 4'h7, pins)
    dbchk(7, 1'b1, 5, 1);
    dbchk(7, 1'b0, 9, 1);
    dbchk(7, 1'b1, 5, 1);
    dbchk(7, 1'b0, 9, 1);
  endtask : s_start

  task automatic s_zero();
    wr(DBR, 8'h00);
    wr(DBF, 8'h00);
    dbchk(7, 1'b1, 0, 0);
    dbchk(7, 1'b0, 0, 0);
    wr(DBR, 8'h3F);
    wr(DBF, 8'h3F);
    dbchk(7, 1'b1, 63, 1);
    dbchk(7, 1'b0, 63, 1);
  endtask : s_zero

  task automatic s_short();
    int s;
    s = 0;
    wr(DBR, 8'h14);
    @(posedge hclk);
    sv[7] <= 1'b1;
    repeat (8) @(posedge hclk);
    sv[7] <= 1'b0;
    repeat (40) begin
      @(posedge hclk);
      s += (pins.output_a === 1'b1);
    end
    `CHK("a_pulses", 0, s)
    wr(DBR, 8'h03);
    wr(DBF, 8'h03);
  endtask : s_short

  task automatic s_pol();
    repeat (80) @(posedge hclk);
    wr(CT0, RUN & ~8'h18);
    repeat (4) @(posedge hclk);
    `CHK("a_b", 2'b10, {pins.output_a, pins.output_b})
    wr(CT0, RUN & ~OA);
    repeat (4) @(posedge hclk);
    `CHK("oe", 2'b01, {pins.output_a_oe, pins.output_b_oe})
    `CHK("pads", 2'b01, {pad_a, pad_b})
    wr(CT0, RUN & ~EN);
    repeat (4) @(posedge hclk);
    `CHK("oe", 2'b00, {pins.output_a_oe, pins.output_b_oe})
    wr(CT0, RUN);
    repeat (2) @(posedge hclk);
    `CHK("a_b", 2'b00, {pins.output_a, pins.output_b})
    // Re-enabling leaves both off; a rise then a timed fall bring back a live b
    @(posedge hclk);
    sv[7] <= 1'b1;
    repeat (20) @(posedge hclk);
    dbchk(7, 1'b0, 3, 1);
  endtask : s_pol

  task automatic s_sd();
    logic [31:0] q;
    dbchk(7, 1'b1, 3, 1);
    wr(CT0, RUN & ~8'h18);
    wr(SHD, ASE | LA);
    repeat (4) @(posedge hclk);
    `CHK("pins", 4'hD, pins)
    repeat (60) @(posedge hclk);
    bus(1'b0, SHD, 32'h0, q);
    `CHK("ase", 1'b1, q[7])
    `CHK("pins", 4'hD, pins)
    bus(1'b0, cwg_pkg::CWG_STAT_OFS, 32'h0, q);
    `CHK("status", 32'h0000_00D7, q)
    `CHK("hresp", 1'b0, hresp)
    wr(SHD, LA);
    resume(4'hD, 4'h7);
    wr(CT0, RUN);
  endtask : s_sd

  task automatic s_ext();
    logic [31:0] q;
    int ix[4] = '{9, 8, 1, 0};
    logic [7:0] sl[4] = '{S0, S0, S1, S1};
    wr(SHD, S1);
    @(posedge hclk);
    sv[9] <= 1'b1;
    repeat (8) @(posedge hclk);
    `CHK("pins", 4'hD, pins)
    sv[9] <= 1'b0;
    for (int k = 0; k < 4; k++) begin
      wr(SHD, sl[k]);
      @(posedge hclk);
      sv[ix[k]] <= 1'b1;
      repeat (8) @(posedge hclk);
      `CHK("pins", 4'h5, pins)
      wr(SHD, sl[k]);
      bus(1'b0, SHD, 32'h0, q);
      `CHK("ase", 1'b1, q[7])
      sv[ix[k]] <= 1'b0;
      repeat (8) @(posedge hclk);
      wr(SHD, sl[k]);
      bus(1'b0, SHD, 32'h0, q);
      `CHK("ase", 1'b0, q[7])
      resume(4'h5, 4'hD);
    end
  endtask : s_ext

  task automatic s_auto();
    logic [31:0] q;
    wr(SHD, ARS | S1);
    @(posedge hclk);
    sv[0] <= 1'b1;
    repeat (8) @(posedge hclk);
    `CHK("pins", 4'h5, pins)
    sv[0] <= 1'b0;
    repeat (12) @(posedge hclk);
    bus(1'b0, SHD, 32'h0, q);
    `CHK("ase", 1'b0, q[7])
    resume(4'h5, 4'hD);
  endtask : s_auto

  // Every input source in turn drives both edges
  task automatic s_sel();
    wr(SHD, 8'h00);
    @(posedge hclk);
    sv <= 10'h000;
    repeat (20) @(posedge hclk);
    for (int i = 0; i < 8; i++) begin
      wr(ISL, 8'(i));
      dbchk(9 - i, 1'b1, 3, 1);
      dbchk(9 - i, 1'b0, 3, 1);
    end
  endtask : s_sel

  // Oscillator ticks stretch the dead band sixteenfold
  task automatic s_osc();
    wr(CT0, RUN | CS);
    wr(DBR, 8'h04);
    repeat (40) @(posedge hclk);
    `CHK("keep_on", 1'b0, hfosc_keep_on)
    dbchk(2, 1'b1, 64, 16);
    `CHK("keep_on", 1'b1, hfosc_keep_on)
    wr(CT0, RUN);
    repeat (2) @(posedge hclk);
    `CHK("keep_on", 1'b0, hfosc_keep_on)
  endtask : s_osc

  // Reset for six cycles, then run every scenario in turn
  initial begin
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    s_reset();
    s_start();
    s_zero();
    s_short();
    s_pol();
    s_sd();
    s_ext();
    s_auto();
    s_sel();
    s_osc();
    stop_test();
  end
endmodule : cwg_top_tb
